// File: pio_pkg.sv
// Constants shared by the parallel I/O port bank and its helpers.
// Assumes a word-indexed register port and 8-bit ports.
`default_nettype none
package pio_pkg;
   // Structure of one unit and of the whole bank
   localparam int NUM_UNITS      = 2;
   localparam int PORTS_PER_UNIT = 12;
   localparam int PORT_W         = 8;
   localparam int AW             = 8;
   localparam int DW             = 32;
   // Port roles inside one unit: A, B, C per group
   localparam int PAT_PORT       = 0;
   localparam int COS_PORT       = 1;
   localparam int C_FIRST        = 2;
   localparam int C_STRIDE       = 3;
   localparam int C_PORTS        = 4;
   // C lines wired to the interrupt logic
   localparam int C_LINE_LO      = 0;
   localparam int C_LINE_HI      = 4;
   // Event layout per unit in the status word
   localparam int EV_PER_UNIT    = 10;
   localparam int EV_PAT         = 8;
   localparam int EV_COS         = 9;
   // Register indices
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_DIR  = 8'h20;
   localparam logic [7:0] ADDR_PAT  = 8'h40;
   localparam logic [7:0] ADDR_EDGE = 8'h44;
   localparam logic [7:0] ADDR_STAT = 8'h48;
   localparam logic [7:0] ADDR_CLR  = 8'h49;
   localparam logic [7:0] ADDR_EN   = 8'h4a;
   // Field positions and reset values
   localparam int DIR_BIT        = 0;
   localparam logic DIR_RST      = 1'b0;
   localparam logic [7:0] OUT_RST = 8'h00;
   localparam logic [7:0] PAT_RST = 8'h00;
   localparam logic [7:0] EDGE_RST = 8'h00;
   // Cycles after reset before events are trusted
   localparam logic [2:0] ARM_CYC = 3'h5;
endpackage
`default_nettype wire

// File: pio_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes inputs are asynchronous to sys_clk.
`timescale 1ns/1ps
`default_nettype none
module pio_sync #(
   parameter int W = 8
) (
   input  wire logic         sys_clk,
   input  wire logic         clr,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] stable
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // Stages, first stage only feeds the second
   always_ff @(posedge sys_clk or posedge clr) begin
      if (clr) begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end else begin
         s1 <= async_in;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Take a new level once stages two and three agree
   always_ff @(posedge sys_clk or posedge clr) begin
      if (clr) begin
         stable <= '0;
      end else begin
         stable <= (s3 & ~(s2 ^ s3)) | (stable & (s2 ^ s3));
      end
   end
endmodule
`default_nettype wire

// File: pio_ports_top.sv
// Bank of 8-bit parallel I/O ports with C-line, pattern-match
// and change-of-state interrupts, plus hot-reset retention.
// Assumes a word-indexed register port on sys_clk, a power-on
// reset por, a hot reset, and external pull-ups on port lines.
//
// Operation
// (R1) Lines form twelve 8-bit ports per unit: A, B and C in four groups.
// (R2) Software picks input or output for every port separately.
// (R3) Ports behave as simple basic I/O with latched, driven outputs.
// (R4) Hot reset keeps or reverts directions and outputs per hold select.
// (R5) Two lines of each C port raise interrupts on a chosen edge.
// (R6) Several interrupt sources may pend at once, each kept apart.
// (R7) Pattern-match port compared to a preset pattern; match interrupts.
// (R8) Any line change on the change-of-state port interrupts.
// (R9) An extension unit adds a second twelve-port set on the same bus.
// (R10) Without hold, software ports return to input after reset.
// (R11) Strapped ports always drive and start at logic 0.
// (R12) Power loss clears retained state; power-up gives the defaults.
// (R13) Inputs are synchronised; requests stay latched until cleared.
// (R14) Reading an output port returns the driven value.
`timescale 1ns/1ps
`default_nettype none
module pio_ports_top #(
   parameter int NUM_UNITS = pio_pkg::NUM_UNITS
) (
   input  wire logic sys_clk,
   input  wire logic reset,
   input  wire logic por,
   input  wire logic reset_hold_select,
   input  wire logic [2*NUM_UNITS*pio_pkg::PORTS_PER_UNIT-1:0] strap_out,
   input  wire logic [NUM_UNITS*pio_pkg::PORTS_PER_UNIT*8-1:0] pin_in,
   output logic      [NUM_UNITS*pio_pkg::PORTS_PER_UNIT*8-1:0] pin_out,
   output logic      [NUM_UNITS*pio_pkg::PORTS_PER_UNIT*8-1:0] pin_oe,
   input  wire logic [pio_pkg::AW-1:0] reg_addr,
   input  wire logic [pio_pkg::DW-1:0] reg_wdata,
   input  wire logic reg_wr,
   input  wire logic reg_rd,
   output logic      [pio_pkg::DW-1:0] reg_rdata,
   output logic      irq
);
   import pio_pkg::*;

   localparam int NP  = NUM_UNITS * PORTS_PER_UNIT;
   localparam int NL  = NP * PORT_W;
   localparam int NEV = NUM_UNITS * EV_PER_UNIT;

   logic [NL-1:0]   in_s;
   logic [2*NP:0]   static_s;
   logic [2*NP-1:0] strap_q;
   logic            hold_q;
   logic            rst_s1;
   logic            rst_s2;
   wire logic [NP-1:0] dir_all;
   wire logic [NL-1:0] out_all;
   wire logic [NL-1:0] oe_all;
   wire logic [NL-1:0] rd_all;
   wire logic [NEV-1:0] ev_all;
   wire logic [2*NP-1:0] chk_nib;
   logic [NEV-1:0]  status;
   logic [NEV-1:0]  enable;
   logic [NEV-1:0]  next_status;
   logic [NEV-1:0]  next_enable;
   logic [DW-1:0]   next_rdata;
   logic [2:0]      arm_cnt;
   logic            armed;
   wire logic [7:0] pat_val [NUM_UNITS];
   wire logic [7:0] edge_val [NUM_UNITS];

   // Field lines, cleared by the hot reset only [R13]
   pio_sync #(.W(NL)) u_pin_sync (
      .sys_clk  (sys_clk),
      .clr      (reset),
      .async_in (pin_in),
      .stable   (in_s)
   );

   // Static straps and hold select, cleared only at power-up
   pio_sync #(.W(2*NP+1)) u_static_sync (
      .sys_clk  (sys_clk),
      .clr      (por),
      .async_in ({reset_hold_select, strap_out}),
      .stable   (static_s)
   );
   assign strap_q = static_s[2*NP-1:0];
   assign hold_q  = static_s[2*NP];

   // Hot reset seen from the retained domain
   always_ff @(posedge sys_clk or posedge por) begin
      if (por) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
      end else begin
         rst_s1 <= reset;
         rst_s2 <= rst_s1;
      end
   end

   // One generate entry per port, all units alike [R1] [R9]
   for (genvar p = 0; p < NP; p++) begin : g_port
      logic       dir;
      logic [7:0] outv;
      wire logic  eff_lo = dir | strap_q[2*p];
      wire logic  eff_hi = dir | strap_q[2*p+1];

      // Direction and latch survive hot reset under hold [R4] [R12]
      always_ff @(posedge sys_clk or posedge por) begin
         if (por) begin
            dir  <= DIR_RST;
            outv <= OUT_RST;
         end else if (rst_s2) begin
            if (!hold_q) begin
               dir  <= DIR_RST; // Back to input [R10]
               outv <= OUT_RST; // Strapped lines drive 0 [R11]
            end
         end else if (reg_wr) begin
            if (reg_addr == ADDR_DIR + 8'(p)) begin
               dir <= reg_wdata[DIR_BIT]; // Per-port direction [R2]
            end
            if (reg_addr == ADDR_DATA + 8'(p)) begin
               outv <= reg_wdata[7:0]; // Latched like basic I/O [R3]
            end
         end
      end

      assign dir_all[p]       = dir;
      assign out_all[p*8 +: 8] = outv;
      // Straps win over a software input choice [R11]
      assign oe_all[p*8 +: 8] = {{4{eff_hi}}, {4{eff_lo}}};
      // Nibble drive as seen on the pins, for the strap check
      assign chk_nib[2*p]     = &pin_oe[p*8 +: 4];
      assign chk_nib[2*p+1]   = &pin_oe[p*8+4 +: 4];
      // Output lines read back their driven level [R14]
      assign rd_all[p*8 +: 8] = (oe_all[p*8 +: 8] & outv)
                              | (~oe_all[p*8 +: 8] & in_s[p*8 +: 8]);
   end

   // Pins follow the retained state from flip-flops [R3]
   always_ff @(posedge sys_clk or posedge por) begin
      if (por) begin
         pin_out <= '0;
         pin_oe  <= '0;
      end else begin
         pin_out <= out_all;
         pin_oe  <= oe_all;
      end
   end

   // Hold off events until synchronisers hold real levels
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         arm_cnt <= 3'h0;
      end else if (arm_cnt != ARM_CYC) begin
         arm_cnt <= arm_cnt + 3'h1;
      end
   end
   assign armed = (arm_cnt == ARM_CYC);

   // Event sources of each unit
   for (genvar u = 0; u < NUM_UNITS; u++) begin : g_unit
      localparam int BASE = u * PORTS_PER_UNIT;
      logic [7:0] pat;
      logic [7:0] edge_sel;
      logic [7:0] c_prev;
      logic [7:0] b_prev;
      logic       match_q;
      wire logic [7:0] a_now = in_s[(BASE+PAT_PORT)*8 +: 8];
      wire logic [7:0] b_now = in_s[(BASE+COS_PORT)*8 +: 8];
      wire logic [7:0] c_now;
      wire logic       hit = (a_now == pat);

      for (genvar g = 0; g < C_PORTS; g++) begin : g_c
         localparam int CP = BASE + C_FIRST + g * C_STRIDE;
         assign c_now[2*g]   = in_s[CP*8 + C_LINE_LO];
         assign c_now[2*g+1] = in_s[CP*8 + C_LINE_HI];
      end

      // Pattern and edge choice per unit
      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            pat      <= PAT_RST;
            edge_sel <= EDGE_RST;
         end else if (reg_wr) begin
            if (reg_addr == ADDR_PAT + 8'(u)) begin
               pat <= reg_wdata[7:0];
            end
            if (reg_addr == ADDR_EDGE + 8'(u)) begin
               edge_sel <= reg_wdata[7:0];
            end
         end
      end

      // Previous samples for edge, change and match detection
      always_ff @(posedge sys_clk or posedge reset) begin
         if (reset) begin
            c_prev  <= 8'h00;
            b_prev  <= 8'h00;
            match_q <= 1'b0;
         end else begin
            c_prev  <= c_now;
            b_prev  <= b_now;
            match_q <= hit;
         end
      end

      // Edge bit 0 picks rising, 1 picks falling [R5]
      assign ev_all[u*EV_PER_UNIT +: 8] = {8{armed}}
         & ((c_now & ~c_prev & ~edge_sel) | (~c_now & c_prev & edge_sel));
      // Entering a match raises one request [R7]
      assign ev_all[u*EV_PER_UNIT + EV_PAT] = armed & hit & ~match_q;
      // Any line differing from its last sample [R8]
      assign ev_all[u*EV_PER_UNIT + EV_COS] = armed & |(b_now ^ b_prev);
      assign pat_val[u]  = pat;
      assign edge_val[u] = edge_sel;
   end

   // Sticky status, set beats clear, separate bits [R6] [R13]
   always_comb begin
      next_status = status;
      next_enable = enable;
      if (reg_wr && reg_addr == ADDR_CLR) begin
         next_status = status & ~reg_wdata[NEV-1:0];
      end
      if (reg_wr && reg_addr == ADDR_EN) begin
         next_enable = reg_wdata[NEV-1:0];
      end
      next_status = next_status | ev_all;
   end

   // Status, enable and the level interrupt
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         status <= '0;
         enable <= '0;
         irq    <= 1'b0;
      end else begin
         status <= next_status;
         enable <= next_enable;
         irq    <= |(next_status & next_enable); // [R6]
      end
   end

   // Read decode; unmapped indices read zero
   always_comb begin
      next_rdata = '0;
      for (int p = 0; p < NP; p++) begin
         if (reg_addr == ADDR_DATA + 8'(p)) begin
            next_rdata[7:0] = rd_all[p*8 +: 8]; // [R14]
         end
         if (reg_addr == ADDR_DIR + 8'(p)) begin
            next_rdata[2:0] = {strap_q[2*p+1], strap_q[2*p], dir_all[p]};
         end
      end
      for (int u = 0; u < NUM_UNITS; u++) begin
         if (reg_addr == ADDR_PAT + 8'(u)) begin
            next_rdata[7:0] = pat_val[u];
         end
         if (reg_addr == ADDR_EDGE + 8'(u)) begin
            next_rdata[7:0] = edge_val[u];
         end
      end
      if (reg_addr == ADDR_STAT) begin
         next_rdata[NEV-1:0] = status;
      end
      if (reg_addr == ADDR_EN) begin
         next_rdata[NEV-1:0] = enable;
      end
   end

   // Read data stand one cycle after the strobe only
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= '0;
      end
   end

   // Helpers seen only by the checks below
   wire logic [7:0] chk_out0 = out_all[7:0];
   wire logic [7:0] chk_wlow = reg_wdata[7:0];
   wire logic [7:0] chk_b0   = in_s[COS_PORT*8 +: 8];
   wire logic       chk_c0   = in_s[C_FIRST*8 + C_LINE_LO];
   wire logic       chk_hit0 = (in_s[7:0] == pat_val[0]);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset || por);

   a_dir_write_out: assert property ( // [R2]
      (reg_wr && reg_addr == ADDR_DIR && reg_wdata[DIR_BIT] && !rst_s2)
      |=> ##1 pin_oe[7:0] == 8'hff)
      else $error("port direction write did not reach the pins");

   a_data_write_pin: assert property ( // [R3]
      (reg_wr && reg_addr == ADDR_DATA && !rst_s2)
      |=> ##1 pin_out[7:0] == $past(chk_wlow, 2))
      else $error("output latch write did not reach the pins");

   a_strap_forces_out: assert property ( // [R11]
      (strap_q != '0)
      |=> ((chk_nib & $past(strap_q)) == $past(strap_q)))
      else $error("strapped nibble is not driven");

   a_output_readback: assert property ( // [R14]
      (reg_rd && reg_addr == ADDR_DATA && oe_all[7:0] == 8'hff)
      |=> reg_rdata[7:0] == $past(chk_out0))
      else $error("output port read did not return driven value");

   a_c_edge_flag: assert property ( // [R5]
      (armed && $rose(chk_c0) && !edge_val[0][0]) |=> status[0])
      else $error("C line rising edge did not set its flag");

   a_pattern_flag: assert property ( // [R7]
      (armed && $rose(chk_hit0)) |=> status[EV_PAT])
      else $error("pattern match did not set its flag");

   a_change_flag: assert property ( // [R8]
      (armed && $past(armed) && chk_b0 != $past(chk_b0))
      |=> status[EV_COS])
      else $error("line change did not set its flag");

   a_flag_sticky: assert property ( // [R13]
      (status[0] && !(reg_wr && reg_addr == ADDR_CLR && reg_wdata[0]))
      |=> status[0])
      else $error("pending request vanished without a clear");

   a_irq_pending: assert property ( // [R6]
      (|(status & enable)) |-> irq)
      else $error("interrupt low while an enabled request pends");

   a_hold_keeps: assert property ( // [R4]
      @(posedge sys_clk) disable iff (por)
      (rst_s2 && hold_q) |=> ($stable(dir_all) && $stable(out_all)))
      else $error("retained port state changed during hot reset");

   a_revert_default: assert property ( // [R10]
      @(posedge sys_clk) disable iff (por)
      (rst_s2 && !hold_q) |=> (dir_all == '0 && out_all == '0))
      else $error("ports did not return to defaults on reset");
endmodule
`default_nettype wire

// File: pio_field.sv
// Field wiring model for the port bank: pull-ups and switches.
// Assumes pin_oe high means the bank drives that line.
`timescale 1ns/1ps
`default_nettype none
module pio_field #(
   parameter int NL = 192
) (
   input  wire logic [NL-1:0] pin_out,
   input  wire logic [NL-1:0] pin_oe,
   input  wire logic [NL-1:0] sw_en,
   input  wire logic [NL-1:0] sw_val,
   output logic      [NL-1:0] pin_in
);
   // Bank drive wins, then a closed switch, else the pull-up level
   always_comb begin
      for (int i = 0; i < NL; i++) begin
         pin_in[i] = pin_oe[i] ? pin_out[i]
                   : (sw_en[i] ? sw_val[i] : 1'b1);
      end
   end
endmodule
`default_nettype wire

// File: pio_tb.sv
// Self-checking bench for the parallel I/O port bank.
// Assumes pio_pkg, pio_ports_top and pio_field are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import pio_pkg::*;
   localparam int NL = 192;
   logic          sys_clk, reset, por, reset_hold_select, irq;
   logic [47:0]   strap_out;
   logic [NL-1:0] pin_in, pin_out, pin_oe, sw_en, sw_val;
   logic [AW-1:0] reg_addr;
   logic [DW-1:0] reg_wdata, reg_rdata;
   logic          reg_wr, reg_rd, rd_pend;
   logic [31:0]   exp_q[$];
   logic [7:0]    adr_q[$];
   logic [31:0]   seed, v, v3;
   int            errors, total_checks;

   pio_ports_top i_dut (.sys_clk(sys_clk), .reset(reset), .por(por),
      .reset_hold_select(reset_hold_select), .strap_out(strap_out),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
   pio_field #(.NL(NL)) i_field (.pin_out(pin_out), .pin_oe(pin_oe),
      .sw_en(sw_en), .sw_val(sw_val), .pin_in(pin_in));

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // One-cycle register write
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   // One-cycle register read; the expected word waits in the queue
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      adr_q.push_back(a);
      @(posedge sys_clk);
      reg_rd <= 1'b0;
   endtask

   // Bounded wait for the interrupt line
   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 40) begin
         @(posedge sys_clk);
         n++;
      end
      if (irq !== 1'b1) begin
         errors++;
         $display("CHECK FAILED irq expected 1 seen %b", irq);
         end_sim();
      end
   endtask

   // Read data stand only in the cycle after the strobe
   always @(posedge sys_clk) begin
      if (rd_pend) begin
         chk($sformatf("reg %h", adr_q.pop_front()), exp_q.pop_front(),
             reg_rdata);
      end
      rd_pend <= reg_rd;
   end

   // 200 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   initial begin
      reset = 1'b1;
      por = 1'b1;
      reset_hold_select = 1'b0;
      strap_out = 48'h000000000c00;
      sw_en = '0;
      sw_val = '0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      seed = 32'ha5a6;
      v3 = '0;
      errors = 0;
      total_checks = 0;
      tick(8);
      por <= 1'b0;
      reset <= 1'b0;
      tick(20);
      chk("oe port3", 8'h00, pin_oe[24+:8]);
      chk("oe port5", 8'hff, pin_oe[40+:8]);
      chk("out port5", 8'h00, pin_out[40+:8]);
      rd(ADDR_DATA + 8'h04, 32'hff);
      rd(ADDR_DIR + 8'h05, 32'h6);
      rd(8'h60, 32'h0);
      $display("test defaults done");
      // Every port of unit 0 from port 3 to port 11 to output with random data
      for (int p = 3; p < 12; p++) begin
         seed = lfsr(seed);
         if (p == 3) v3 = {24'h0, seed[7:0]};
         wr(ADDR_DIR + 8'(p), 32'h1);
         wr(ADDR_DATA + 8'(p), {24'h0, seed[7:0]});
         tick(2);
         chk("pin_out", seed[7:0], pin_out[p*8+:8]);
         chk("pin_oe", 8'hff, pin_oe[p*8+:8]);
         rd(ADDR_DATA + 8'(p), {24'h0, seed[7:0]});
         rd(ADDR_DIR + 8'(p), (p == 5) ? 32'h7 : 32'h1);
      end
      $display("test directions done");
      // Interrupt sources
      wr(ADDR_EN, 32'hfffff);
      wr(ADDR_CLR, 32'hfffff);
      rd(ADDR_STAT, 32'h0);
      sw_en[16] <= 1'b1;
      tick(12);
      rd(ADDR_STAT, 32'h0);
      sw_en[16] <= 1'b0;
      wait_irq();
      rd(ADDR_STAT, 32'h1);
      // Falling edge choice on the same C line
      wr(ADDR_EDGE, 32'h1);
      wr(ADDR_CLR, 32'h1);
      rd(ADDR_STAT, 32'h0);
      sw_en[16] <= 1'b1;
      tick(12);
      rd(ADDR_EDGE, 32'h1);
      rd(ADDR_STAT, 32'h1);
      seed = lfsr(seed);
      v = {25'h0, seed[6:0]};
      wr(ADDR_PAT, v);
      sw_val[7:0] <= v[7:0];
      sw_en[7:0] <= 8'hff;
      tick(12);
      sw_en[11] <= 1'b1;
      tick(12);
      sw_en[104] <= 1'b1;
      tick(12);
      rd(ADDR_STAT, 32'h80301);
      wr(ADDR_EN, 32'h0);
      tick(2);
      chk("irq masked", 1'b0, irq);
      wr(ADDR_EN, 32'hfffff);
      tick(2);
      chk("irq enabled", 1'b1, irq);
      wr(ADDR_CLR, 32'h101);
      rd(ADDR_STAT, 32'h80200);
      rd(ADDR_CLR, 32'h0);
      wr(ADDR_CLR, 32'hfffff);
      tick(2);
      chk("irq cleared", 1'b0, irq);
      $display("test interrupts done");
      // Hot reset with and without hold, then power loss
      reset_hold_select <= 1'b1;
      tick(5);
      reset <= 1'b1;
      tick(2);
      reset <= 1'b0;
      tick(10);
      chk("held oe", 8'hff, pin_oe[24+:8]);
      chk("held out", v3, pin_out[24+:8]);
      rd(ADDR_DIR + 8'h03, 32'h1);
      reset_hold_select <= 1'b0;
      tick(5);
      reset <= 1'b1;
      tick(2);
      reset <= 1'b0;
      tick(10);
      chk("revert oe", 8'h00, pin_oe[24+:8]);
      chk("strap out", 8'h00, pin_out[40+:8]);
      chk("strap oe", 8'hff, pin_oe[40+:8]);
      rd(ADDR_DIR + 8'h03, 32'h0);
      reset_hold_select <= 1'b1;
      wr(ADDR_DIR + 8'h03, 32'h1);
      tick(5);
      por <= 1'b1;
      tick(2);
      por <= 1'b0;
      tick(10);
      chk("por oe", 8'h00, pin_oe[24+:8]);
      // Pattern port driven as output after power-up
      seed = lfsr(seed);
      wr(ADDR_DIR, 32'h1);
      wr(ADDR_DATA, {24'h0, seed[7:0]});
      tick(2);
      chk("oe port0", 8'hff, pin_oe[7:0]);
      chk("out port0", seed[7:0], pin_out[7:0]);
      rd(ADDR_DATA, {24'h0, seed[7:0]});
      $display("test resets done");
      tick(4);
      end_sim();
   end
endmodule
`default_nettype wire
